//--- src/otf_top.v
// Purpose: offset trim registers and IIR offset filter with AXI4-Lite
// Assumes: samples from one core at a time, tagged with core and input
// Notes: output stream passes a two-entry skid buffer
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "otf_map.vh"

module otf_top #(
  parameter DW = 16,
  parameter [11:0] FACTORY_TRIM = `OTF_RST_TRIM
) (
  // clock and reset
  input wire CORE_CLK,
  input wire RST_N,
  // axi4-lite write
  input wire [11:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output reg S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output reg S_AXI_WREADY,
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  // axi4-lite read
  input wire [11:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output reg S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY,
  // calibration engine status
  input wire FOREGROUND_CAL_FINISHED_IN,
  input wire BG_HALTED_IN,
  input wire CORE_CALIBRATED,
  // sample stream in: core 0=a 1=b 2=c, input 0=a 1=b
  input wire [DW-1:0] IN_DATA,
  input wire [1:0] IN_CORE,
  input wire IN_SEL,
  input wire IN_VALID,
  output reg IN_READY,
  // sample stream out
  output reg [DW-1:0] OUT_DATA,
  output reg OUT_VALID,
  input wire OUT_READY,
  output reg CORE_ONLINE
);

  // trim index: 0 a_inb,1 c_ina,2 c_inb,3 b_ina,4 b_inb, 7 none
  function [2:0] trim_sel;
    input [8:0] idx;
    begin
      case (idx)
        `OTF_IDX_TRIM_A_INB: trim_sel = 3'h0;
        `OTF_IDX_TRIM_C_INA: trim_sel = 3'h1;
        `OTF_IDX_TRIM_C_INB: trim_sel = 3'h2;
        `OTF_IDX_TRIM_B_INA: trim_sel = 3'h3;
        `OTF_IDX_TRIM_B_INB: trim_sel = 3'h4;
        default: trim_sel = 3'h7;
      endcase
    end
  endfunction

  reg [15:0] trim [0:4];
  reg [7:0] filt_low;
  reg [7:0] filt_high;
  reg [`OTF_CTRL_W-1:0] cal_ctrl;
  reg [11:0] aw_addr;
  reg aw_have;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_have;
  reg [8:0] rd_idx;
  reg [31:0] rd_word;
  reg rd_ok;
  reg [2:0] wsel;
  reg wr_ok;
  reg [31:0] acc;
  reg [31:0] mismatch;
  reg [17:0] soak_cnt;
  reg [DW-1:0] buf_data [0:1];
  reg [1:0] buf_cnt;
  reg buf_wr;
  reg [DW-1:0] next_out;
  integer i;

  wire [3:0] bw_code = filt_high[7:4];
  wire [3:0] soak_code = filt_high[3:0];
  wire dc_preserve = filt_low[0];
  wire filt_on = cal_ctrl[`OTF_CTRL_FILT];
  wire bg_on = cal_ctrl[`OTF_CTRL_BG];
  wire bgos_on = cal_ctrl[`OTF_CTRL_BGOS];
  // reserved bandwidth codes leave the filter bypassed
  wire bw_ok = (bw_code >= `OTF_BW_MIN) && (bw_code <= `OTF_BW_MAX);
  // coefficient 2^-(9+code): code 1 gives 2^-10, code 5 gives 2^-14
  wire [4:0] shift = `OTF_SHIFT_BASE + {1'b0, bw_code};
  wire soak_apply = filt_on && bg_on;
  // a write fires once address and data are both held
  wire wr_fire = aw_have && w_have && !S_AXI_BVALID;

  // trim lookup from core and input
  reg [2:0] apply_sel;
  reg [11:0] apply_trim;
  always @* begin
    case ({IN_CORE, IN_SEL})
      3'b001: apply_sel = 3'h0;
      3'b100: apply_sel = 3'h1;
      3'b101: apply_sel = 3'h2;
      3'b010: apply_sel = 3'h3;
      3'b011: apply_sel = 3'h4;
      default: apply_sel = 3'h7;
    endcase
    // core a on input a has no trim here, passes uncorrected
    if (apply_sel == 3'h7)
      apply_trim = 12'h800;
    else
      apply_trim = trim[apply_sel][11:0];
  end

  // write decode; the calibration guards on trim writes are enforced here
  always @* begin
    wsel = trim_sel(aw_addr[10:2]);
    // trim writes during foreground calibration or background offset calibration are refused so trims stay coherent
    wr_ok = !cal_ctrl[`OTF_CTRL_FGRUN] && !(bg_on && bgos_on);
  end

  // read decode
  always @* begin
    rd_idx = S_AXI_ARADDR[10:2];
    rd_ok = 1'b1;
    rd_word = 32'h00000000;
    if (trim_sel(rd_idx) != 3'h7)
      rd_word = {16'h0000, trim[trim_sel(rd_idx)]};
    else case (rd_idx)
      `OTF_IDX_FILT_LOW: rd_word = {24'h000000, filt_low};
      `OTF_IDX_FILT_HIGH: rd_word = {24'h000000, filt_high};
      `OTF_IDX_CAL_CTRL: rd_word = {26'h0000000, cal_ctrl};
      `OTF_IDX_CAL_STAT:
        rd_word = {29'h00000000, CORE_ONLINE, BG_HALTED_IN, FOREGROUND_CAL_FINISHED_IN};
      // holes in the map answer with an error
      default: rd_ok = 1'b0;
    endcase
  end

  // axi write channel and register storage
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY <= 1'b1;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `OTF_RESP_OKAY;
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      for (i = 0; i < 5; i = i + 1)
        trim[i] <= {4'h0, FACTORY_TRIM};
      filt_low <= `OTF_RST_FILT_LOW;
      filt_high <= `OTF_RST_FILT_HIGH;
      cal_ctrl <= {`OTF_CTRL_W{1'b0}};
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_addr <= S_AXI_AWADDR;
        aw_have <= 1'b1;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
        w_have <= 1'b1;
        S_AXI_WREADY <= 1'b0;
      end
      if (wr_fire) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= `OTF_RESP_OKAY;
        aw_have <= 1'b0;
        w_have <= 1'b0;
        if (wsel != 3'h7) begin
          if (!wr_ok)
            S_AXI_BRESP <= `OTF_RESP_SLVERR;
          else begin
            // reserved top nibble is stored as written
            if (w_strb[0])
              trim[wsel][7:0] <= w_data[7:0];
            if (w_strb[1])
              trim[wsel][15:8] <= w_data[15:8];
          end
        end else case (aw_addr[10:2])
          `OTF_IDX_FILT_LOW:
            if (w_strb[0]) filt_low <= w_data[7:0];
          `OTF_IDX_FILT_HIGH:
            if (w_strb[0]) filt_high <= w_data[7:0];
          `OTF_IDX_CAL_CTRL:
            if (w_strb[0]) cal_ctrl <= w_data[`OTF_CTRL_W-1:0];
          `OTF_IDX_CAL_STAT: ;
          default: S_AXI_BRESP <= `OTF_RESP_SLVERR;
        endcase
      end
      // response taken: reopen both channels for the next write
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY <= 1'b1;
      end
    end
  end

  // axi read channel; one read at a time
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= `OTF_RESP_OKAY;
    end else begin
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        // reads are served always; read timing guards are software's
        S_AXI_RDATA <= rd_word;
        S_AXI_RRESP <= rd_ok ? `OTF_RESP_OKAY : `OTF_RESP_SLVERR;
        S_AXI_RVALID <= 1'b1;
        S_AXI_ARREADY <= 1'b0;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
        S_AXI_ARREADY <= 1'b1;
      end
    end
  end

  // datapath: trim correction then iir offset estimate
  wire in_take = IN_VALID && IN_READY;
  wire [DW+1:0] corr = {2'b00, IN_DATA} + {{(DW-10){1'b0}}, apply_trim}
    - {{(DW-10){1'b0}}, 12'h800};
  // sign-extend the corrected sample for the filter arithmetic
  wire [31:0] samp = {{(32-DW){corr[DW-1]}}, corr[DW-1:0]};
  wire [31:0] err = (samp << 10) - acc;
  // one shift by the whole amount gives coefficient 2^-shift
  wire [31:0] err_sh = $signed(err) >>> shift;
  // offset estimate back at sample scale
  wire [31:0] est = $signed(acc) >>> 10;
  // preserve-dc subtracts only this core's deviation from common mean
  wire [31:0] common = $signed(mismatch) >>> 10;
  // kept apart so the shift stays arithmetic outside an unsigned sum
  wire [31:0] mis_step = $signed(acc - mismatch) >>> 4;

  always @* begin
    if (filt_on && bw_ok && (CORE_ONLINE || !soak_apply)) begin
      if (dc_preserve)
        next_out = samp[DW-1:0] - (est[DW-1:0] - common[DW-1:0]);
      else
        next_out = samp[DW-1:0] - est[DW-1:0];
    end else
      next_out = samp[DW-1:0];
  end

  // first-order iir, acc scaled by 2^10
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      acc <= 32'h00000000;
      mismatch <= 32'h00000000;
    end else if (in_take && filt_on && bw_ok) begin
      acc <= acc + err_sh;
      // slow common estimate tracks mean across cores
      mismatch <= mismatch + mis_step;
    end
  end

  // soak counter: online after settle time
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      soak_cnt <= 18'h00000;
      CORE_ONLINE <= 1'b0;
    end else if (!soak_apply) begin
      soak_cnt <= 18'h00000;
      CORE_ONLINE <= 1'b1;
    end else if (CORE_CALIBRATED) begin
      // two spare bits: long codes must not wrap to zero and stall
      soak_cnt <= {2'b00, `OTF_SOAK_UNIT} << soak_code[2:0];
      CORE_ONLINE <= 1'b0;
    end else if (soak_cnt != 18'h00000) begin
      soak_cnt <= soak_cnt - 18'h00001;
      CORE_ONLINE <= (soak_cnt == 18'h00001);
    end
  end

  // two-entry buffer, back-pressure via IN_READY
  always @* begin
    buf_wr = in_take;
  end
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      buf_cnt <= 2'h0;
      OUT_VALID <= 1'b0;
      OUT_DATA <= {DW{1'b0}};
      IN_READY <= 1'b0;
      buf_data[0] <= {DW{1'b0}};
      buf_data[1] <= {DW{1'b0}};
    end else begin
      // pop first; a write in the same cycle refills behind it
      if (OUT_VALID && OUT_READY) begin
        if (buf_cnt == 2'h2) begin
          OUT_DATA <= buf_data[1];
          buf_cnt <= buf_wr ? 2'h2 : 2'h1;
          if (buf_wr)
            buf_data[1] <= next_out;
        end else if (buf_wr) begin
          OUT_DATA <= next_out;
        end else begin
          OUT_VALID <= 1'b0;
          buf_cnt <= 2'h0;
        end
      end else if (buf_wr) begin
        if (!OUT_VALID) begin
          OUT_DATA <= next_out;
          OUT_VALID <= 1'b1;
          buf_cnt <= 2'h1;
        end else begin
          buf_data[1] <= next_out;
          buf_cnt <= 2'h2;
        end
      end
      // ready only while the skid slot is free after this edge
      IN_READY <= !(buf_cnt == 2'h2 || (buf_cnt == 2'h1 && buf_wr
        && !(OUT_VALID && OUT_READY)));
    end
  end

endmodule

//--- src/otf_map.vh
// Purpose: register offsets, fields, resets and timing counts for the
//   offset trim and filter block
// Assumes: AXI4-Lite byte addressing, one 32-bit word per register
// Notes: printed offsets are not all multiples of four, so each is kept
//   as an index and the byte address is four times the index
`ifndef OTF_MAP_VH
`define OTF_MAP_VH

// register indices as printed
`define OTF_IDX_TRIM_A_INB 9'h08C
`define OTF_IDX_TRIM_C_INA 9'h08E
`define OTF_IDX_TRIM_C_INB 9'h090
`define OTF_IDX_TRIM_B_INA 9'h092
`define OTF_IDX_TRIM_B_INB 9'h094
`define OTF_IDX_FILT_LOW 9'h097
`define OTF_IDX_FILT_HIGH 9'h098
// own registers: calibration control and status
`define OTF_IDX_CAL_CTRL 9'h0A0
`define OTF_IDX_CAL_STAT 9'h0A1

// control fields
`define OTF_CTRL_BG 0
`define OTF_CTRL_BGOS 1
`define OTF_CTRL_FGOS 2
`define OTF_CTRL_FILT 3
`define OTF_CTRL_FGRUN 4
`define OTF_CTRL_STOP 5
`define OTF_CTRL_W 6

// reset values
`define OTF_RST_FILT_LOW 8'h00
`define OTF_RST_FILT_HIGH 8'h33
`define OTF_RST_TRIM 12'h800

// bandwidth codes and soak base
`define OTF_BW_MIN 4'h1
`define OTF_BW_MAX 4'h5
`define OTF_SHIFT_BASE 5'h09
`define OTF_SOAK_UNIT 16'h0400

// bus answers
`define OTF_RESP_OKAY 2'h0
`define OTF_RESP_SLVERR 2'h2

`endif

//--- testbench/otf_props.sv
// Purpose: port checks for the offset trim and filter block
// Assumes: bound to otf_top, one clock, sync reset
// Notes: all checks sleep while reset is low
`timescale 1ns/1ps
module otf_props #(
  parameter DW = 16
) (
  // clock and reset
  input wire CORE_CLK,
  input wire RST_N,
  // register bus
  input wire [11:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  input wire S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  input wire S_AXI_WREADY,
  input wire [1:0] S_AXI_BRESP,
  input wire S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [11:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  input wire S_AXI_ARREADY,
  input wire [31:0] S_AXI_RDATA,
  input wire [1:0] S_AXI_RRESP,
  input wire S_AXI_RVALID,
  input wire S_AXI_RREADY,
  // engine status and sample stream
  input wire FOREGROUND_CAL_FINISHED_IN,
  input wire BG_HALTED_IN,
  input wire CORE_CALIBRATED,
  input wire [DW-1:0] IN_DATA,
  input wire [1:0] IN_CORE,
  input wire IN_SEL,
  input wire IN_VALID,
  input wire IN_READY,
  input wire [DW-1:0] OUT_DATA,
  input wire OUT_VALID,
  input wire OUT_READY,
  input wire CORE_ONLINE
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);
  // answers stand until taken, refusals included
  chk_bresp_hold: assert property (
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("bresp not held");
  chk_rdata_hold: assert property (
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("rdata not held");
  chk_write_lat: assert property (
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
    |-> !S_AXI_BVALID ##2 S_AXI_BVALID) else $error("write answer late");
  chk_read_lat: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read answer late");
  chk_rdata_upper: assert property (
    S_AXI_RVALID |-> S_AXI_RDATA[31:16] == 16'h0000)
    else $error("read data above bit 15");
  chk_one_write: assert property (
    S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("second write accepted");
  chk_out_hold: assert property (
    OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_DATA))
    else $error("stalled word changed");
  chk_out_lat: assert property (
    IN_VALID && IN_READY |=> OUT_VALID) else $error("sample lost");
  chk_reset_idle: assert property (
    $rose(RST_N) |-> !S_AXI_BVALID && !S_AXI_RVALID && !OUT_VALID)
    else $error("busy after reset");
  // main scenarios reached
  cov_write: cover property (S_AXI_BVALID && S_AXI_BREADY);
  cov_stall: cover property (OUT_VALID && !OUT_READY && !IN_READY);
  cov_soak: cover property (CORE_CALIBRATED ##1 !CORE_ONLINE);
endmodule

bind otf_top otf_props #(.DW(DW)) u_props (.*);

//--- testbench/otf_top_tb.sv
// Purpose: register and stream tests for the offset trim and filter
// Assumes: byte address is four times the register index
// Notes: ports share names with the design, joined by name
`timescale 1ns/1ps
`include "otf_map.vh"
module otf_top_tb;
  reg CORE_CLK, RST_N, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY;
  reg S_AXI_ARVALID, S_AXI_RREADY, FOREGROUND_CAL_FINISHED_IN, BG_HALTED_IN;
  reg CORE_CALIBRATED, IN_SEL, IN_VALID, OUT_READY;
  reg [11:0] S_AXI_AWADDR, S_AXI_ARADDR;
  reg [31:0] S_AXI_WDATA;
  reg [3:0] S_AXI_WSTRB;
  reg [15:0] IN_DATA;
  reg [1:0] IN_CORE;
  wire S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
  wire S_AXI_RVALID, IN_READY, OUT_VALID, CORE_ONLINE;
  wire [1:0] S_AXI_BRESP, S_AXI_RRESP;
  wire [31:0] S_AXI_RDATA;
  wire [15:0] OUT_DATA;
  integer bad_count, checks, cyc, n, k;
  reg [11:0] p;
  otf_top u_dut (.*);
  // clock
  initial begin
    CORE_CLK = 1'b0;
    forever #12.5 CORE_CLK = ~CORE_CLK;
  end
  // hang guard, run is near 2200 cycles
  always @(posedge CORE_CLK) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      end_of_test;
    end
  end
  // trim index, core, input select
  function [11:0] pr(input integer i);
    case (i)
      0: pr = {`OTF_IDX_TRIM_A_INB, 2'h0, 1'b1};
      1: pr = {`OTF_IDX_TRIM_C_INA, 2'h2, 1'b0};
      2: pr = {`OTF_IDX_TRIM_C_INB, 2'h2, 1'b1};
      3: pr = {`OTF_IDX_TRIM_B_INA, 2'h1, 1'b0};
      default: pr = {`OTF_IDX_TRIM_B_INB, 2'h1, 1'b1};
    endcase
  endfunction
  task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
    begin
      checks = checks + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("BAD %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  // one write, both channels offered together
  task wr(input [8:0] i, input [31:0] d, input [3:0] s, input [1:0] e);
    begin
      S_AXI_AWADDR <= {1'b0, i, 2'b00};
      S_AXI_WDATA <= d;
      S_AXI_WSTRB <= s;
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID <= 1'b1;
      // no cycle count assumed; the bench timeout ends a hang
      do begin
        @(posedge CORE_CLK);
        if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
        if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      end while (!S_AXI_BVALID);
      chk("bresp", {30'h0, e}, {30'h0, S_AXI_BRESP});
    end
  endtask
  task rdc(input [8:0] i, input [31:0] e, input [1:0] er);
    begin
      S_AXI_ARADDR <= {1'b0, i, 2'b00};
      S_AXI_ARVALID <= 1'b1;
      do begin
        @(posedge CORE_CLK);
        if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      end while (!S_AXI_RVALID);
      chk("rdata", e, S_AXI_RDATA);
      chk("rresp", {30'h0, er}, {30'h0, S_AXI_RRESP});
    end
  endtask
  // one sample in, corrected sample out
  task snd(input [2:0] cs, input [15:0] d, input [15:0] e);
    begin
      {IN_CORE, IN_SEL} <= cs;
      IN_DATA <= d;
      IN_VALID <= 1'b1;
      do begin
        @(posedge CORE_CLK);
      end while (!IN_READY);
      IN_VALID <= 1'b0;
      do begin
        @(posedge CORE_CLK);
      end while (!OUT_VALID);
      chk("out", {16'h0, e}, {16'h0, OUT_DATA});
    end
  endtask
  task end_of_test;
    begin
      $display("bad_count %0d checks %0d", bad_count, checks);
      if (bad_count == 0 && checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  // main sequence
  initial begin
    {RST_N, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_ARVALID, FOREGROUND_CAL_FINISHED_IN} = 0;
    {BG_HALTED_IN, CORE_CALIBRATED, IN_SEL, IN_VALID, IN_CORE} = 0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, S_AXI_WSTRB, IN_DATA} = 0;
    {S_AXI_BREADY, S_AXI_RREADY, OUT_READY} = 3'h7;
    bad_count = 0;
    checks = 0;
    cyc = 0;
    repeat (16) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    @(posedge CORE_CLK);
    for (k = 0; k < 5; k = k + 1) begin
      p = pr(k);
      rdc(p[11:3], 32'h00000800, 2'h0);
      wr(p[11:3], 32'h00000810 + k * 17, 4'h3, 2'h0);
      snd(p[2:0], 16'h1000, 16'h1010 + k * 17);
    end
    snd(3'h0, 16'h1234, 16'h1234);
    rdc(`OTF_IDX_FILT_LOW, 32'h00000000, 2'h0);
    rdc(`OTF_IDX_FILT_HIGH, 32'h00000033, 2'h0);
    wr(`OTF_IDX_FILT_LOW, 32'h00000001, 4'h1, 2'h0);
    rdc(`OTF_IDX_FILT_LOW, 32'h00000001, 2'h0);
    wr(9'h096, 32'h00000001, 4'hF, 2'h2);
    rdc(9'h096, 32'h00000000, 2'h2);
    wr(`OTF_IDX_TRIM_A_INB, 32'h0000FFFF, 4'hF, 2'h0);
    rdc(`OTF_IDX_TRIM_A_INB, 32'h0000FFFF, 2'h0);
    wr(`OTF_IDX_TRIM_A_INB, 32'h000012AB, 4'h1, 2'h0);
    rdc(`OTF_IDX_TRIM_A_INB, 32'h0000FFAB, 2'h0);
    wr(`OTF_IDX_CAL_CTRL, 32'h00000010, 4'h1, 2'h0);
    wr(`OTF_IDX_TRIM_C_INA, 32'h00000123, 4'h3, 2'h2);
    wr(`OTF_IDX_CAL_CTRL, 32'h00000003, 4'h1, 2'h0);
    wr(`OTF_IDX_TRIM_C_INA, 32'h00000123, 4'h3, 2'h2);
    FOREGROUND_CAL_FINISHED_IN <= 1'b1;
    BG_HALTED_IN <= 1'b1;
    rdc(`OTF_IDX_CAL_STAT, 32'h00000007, 2'h0);
    rdc(`OTF_IDX_TRIM_C_INA, 32'h00000821, 2'h0);
    wr(`OTF_IDX_CAL_CTRL, 32'h00000004, 4'h1, 2'h0);
    rdc(`OTF_IDX_CAL_STAT, 32'h00000007, 2'h0);
    rdc(`OTF_IDX_TRIM_B_INA, 32'h00000843, 2'h0);
    wr(`OTF_IDX_CAL_CTRL, 32'h00000000, 4'h1, 2'h0);
    // fill the buffer with the reader stalled, then drain
    OUT_READY <= 1'b0;
    {IN_CORE, IN_SEL} <= 3'h0;
    IN_DATA <= 16'h0100;
    IN_VALID <= 1'b1;
    n = 0;
    repeat (6) begin
      @(posedge CORE_CLK);
      if (IN_READY) begin
        n = n + 1;
        IN_DATA <= IN_DATA + 16'h0001;
      end
    end
    IN_VALID <= 1'b0;
    OUT_READY <= 1'b1;
    chk("fill", 32'h00000002, n);
    k = 0;
    repeat (6) begin
      @(posedge CORE_CLK);
      if (OUT_VALID) begin
        chk("drain", 32'h00000100 + k, {16'h0, OUT_DATA});
        k = k + 1;
      end
    end
    chk("drained", 32'h00000002, k);
    // filter on, code 1, all dc removed: estimate after n samples of D
    // is D*(1-(1-2^-10)^n) truncated, so 0, 4, 7 for D of 0x1000
    wr(`OTF_IDX_FILT_HIGH, 32'h00000011, 4'h1, 2'h0);
    rdc(`OTF_IDX_FILT_HIGH, 32'h00000011, 2'h0);
    wr(`OTF_IDX_FILT_LOW, 32'h00000000, 4'h1, 2'h0);
    wr(`OTF_IDX_CAL_CTRL, 32'h00000008, 4'h1, 2'h0);
    snd(3'h0, 16'h1000, 16'h1000);
    snd(3'h0, 16'h1000, 16'h0FFC);
    snd(3'h0, 16'h1000, 16'h0FF9);
    // soak only with filter and background calibration on
    CORE_CALIBRATED <= 1'b1;
    @(posedge CORE_CLK);
    CORE_CALIBRATED <= 1'b0;
    repeat (4) @(posedge CORE_CLK);
    chk("online", 32'h00000001, {31'h0, CORE_ONLINE});
    wr(`OTF_IDX_CAL_CTRL, 32'h00000009, 4'h1, 2'h0);
    CORE_CALIBRATED <= 1'b1;
    @(posedge CORE_CLK);
    CORE_CALIBRATED <= 1'b0;
    repeat (1000) @(posedge CORE_CLK);
    chk("soaking", 32'h00000000, {31'h0, CORE_ONLINE});
    // online at the 0x800th edge after the pulse, seen one edge later
    n = 1000;
    while (CORE_ONLINE !== 1'b1 && n < 3000) begin
      @(posedge CORE_CLK);
      n = n + 1;
    end
    chk("soaked", 32'h00000001, {31'h0, CORE_ONLINE});
    chk("soak_len", 32'h00000801, n);
    end_of_test;
  end
endmodule
